/* File: src/ss_mod_pkg.sv */
// Purpose: constants and register map of the pll0 spread-spectrum modulator
// Assumes: registers written through the device's internal configuration port
// Notes:   all widths fixed; one byte per register address
package ss_mod_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_SAMPLES = 6;
   localparam int FIELD_W = 4;
   localparam int OFFSET_W = 6;
   localparam int WAVE_W = 8;
   localparam int OUT_W = 10;

   // register offsets
   localparam logic [ADDR_W-1:0] SS_STEP_AND_SAMPLE_COUNT_PLL0 = 8'h60;
   localparam logic [ADDR_W-1:0] SS_DITHER_DOUBLE_OFFSET_PLL0  = 8'h61;
   localparam logic [ADDR_W-1:0] SS_DELTA_SAMPLES_0_1_PLL0     = 8'h62;
   localparam logic [ADDR_W-1:0] SS_DELTA_SAMPLES_2_3_PLL0     = 8'h63;
   localparam logic [ADDR_W-1:0] SS_DELTA_SAMPLES_4_5_PLL0     = 8'h64;

   // reset values
   localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

   // field positions
   localparam int STEP_PERIOD_LSB  = 4;
   localparam int SAMPLE_COUNT_LSB = 0;
   localparam int DITHER_BIT       = 7;
   localparam int DOUBLE_BIT       = 6;
   localparam int START_OFFSET_LSB = 0;
   localparam int DELTA_HI_LSB     = 4;
   localparam int DELTA_LO_LSB     = 0;

   // dither source
   localparam logic [7:0] LFSR_SEED = 8'h01;
   localparam logic [7:0] LFSR_TAPS = 8'hb8;

   typedef enum logic [1:0] {
      SS_IDLE,
      SS_RUN
   } ss_state_t;

endpackage

/* File: src/ss_step_timer.sv */
// Purpose: counts pfd cycles and marks the end of each waveform step
// Assumes: period changes act at once; a count at or past the new period minus one ends the step in that cycle
// Notes:   step_done pulses for one cycle every period cycles while run is high
`timescale 1ns/100ps
module ss_step_timer (
   // clock and reset
   input  wire logic                           sys_clk,
   input  wire logic                           resetn,
   // control
   input  wire logic                           run,
   input  wire logic [ss_mod_pkg::FIELD_W-1:0] period,
   // status
   output logic                                step_done
);

   import ss_mod_pkg::*;

   logic [FIELD_W-1:0] count_reg;
   logic [FIELD_W-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      if (!run) begin
         count_next = '0;
      end else if (count_reg >= period - 4'h1) begin
         count_next = '0;
      end else begin
         count_next = count_reg + 4'h1;
      end
   end

   // the period can read zero for one cycle before run drops; that must not fire a step
   assign step_done = run && (period != '0) && (count_reg >= period - 4'h1);

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

endmodule

/* File: src/pll_spread_spectrum_modulator.sv */
// Purpose: builds the stepped fractional-offset waveform for the pll0 feedback divider
// Assumes: sys_clk is the pfd clock; config writes are single-cycle strobes
// Notes:   read data appears one cycle after the read address is presented
`timescale 1ns/100ps
module pll_spread_spectrum_modulator (
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          resetn,
   // configuration port
   input  wire logic                          cfg_wr,
   input  wire logic [ss_mod_pkg::ADDR_W-1:0] cfg_addr,
   input  wire logic [ss_mod_pkg::DATA_W-1:0] cfg_wdata,
   output logic      [ss_mod_pkg::DATA_W-1:0] cfg_rdata,
   // feedback divider side
   output logic      [ss_mod_pkg::OUT_W-1:0]  frac_offset,
   output logic                               ss_active,
   output logic                               step_strobe
);

   import ss_mod_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers

   logic [DATA_W-1:0] step_cnt_reg;
   logic [DATA_W-1:0] step_cnt_next;
   logic [DATA_W-1:0] dith_off_reg;
   logic [DATA_W-1:0] dith_off_next;
   logic [DATA_W-1:0] delta01_reg;
   logic [DATA_W-1:0] delta01_next;
   logic [DATA_W-1:0] delta23_reg;
   logic [DATA_W-1:0] delta23_next;
   logic [DATA_W-1:0] delta45_reg;
   logic [DATA_W-1:0] delta45_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   always_comb begin
      step_cnt_next = step_cnt_reg;
      dith_off_next = dith_off_reg;
      delta01_next  = delta01_reg;
      delta23_next  = delta23_reg;
      delta45_next  = delta45_reg;
      if (cfg_wr) begin
         case (cfg_addr)
            SS_STEP_AND_SAMPLE_COUNT_PLL0: step_cnt_next = cfg_wdata;
            SS_DITHER_DOUBLE_OFFSET_PLL0:  dith_off_next = cfg_wdata;
            SS_DELTA_SAMPLES_0_1_PLL0:     delta01_next  = cfg_wdata;
            SS_DELTA_SAMPLES_2_3_PLL0:     delta23_next  = cfg_wdata;
            SS_DELTA_SAMPLES_4_5_PLL0:     delta45_next  = cfg_wdata;
            default: begin
            end
         endcase
      end
      case (cfg_addr)
         SS_STEP_AND_SAMPLE_COUNT_PLL0: rdata_next = step_cnt_reg;
         SS_DITHER_DOUBLE_OFFSET_PLL0:  rdata_next = dith_off_reg;
         SS_DELTA_SAMPLES_0_1_PLL0:     rdata_next = delta01_reg;
         SS_DELTA_SAMPLES_2_3_PLL0:     rdata_next = delta23_reg;
         SS_DELTA_SAMPLES_4_5_PLL0:     rdata_next = delta45_reg;
         default:                       rdata_next = REG_RESET;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         step_cnt_reg <= REG_RESET;
         dith_off_reg <= REG_RESET;
         delta01_reg  <= REG_RESET;
         delta23_reg  <= REG_RESET;
         delta45_reg  <= REG_RESET;
         rdata_reg    <= REG_RESET;
      end else begin
         step_cnt_reg <= step_cnt_next;
         dith_off_reg <= dith_off_next;
         delta01_reg  <= delta01_next;
         delta23_reg  <= delta23_next;
         delta45_reg  <= delta45_next;
         rdata_reg    <= rdata_next;
      end
   end

   assign cfg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // field decode

   logic [FIELD_W-1:0]  step_period_cycles;
   logic [FIELD_W-1:0]  sample_count;
   logic [FIELD_W-1:0]  used_count;
   logic [OFFSET_W-1:0] start_offset;
   logic                lsb_dither_enable;
   logic                modulator_output_double;
   logic [FIELD_W-1:0]  delta_samples [NUM_SAMPLES];

   assign step_period_cycles      = step_cnt_reg[STEP_PERIOD_LSB +: FIELD_W];
   assign sample_count            = step_cnt_reg[SAMPLE_COUNT_LSB +: FIELD_W];
   assign start_offset            = dith_off_reg[START_OFFSET_LSB +: OFFSET_W];
   assign lsb_dither_enable       = dith_off_reg[DITHER_BIT];
   assign modulator_output_double = dith_off_reg[DOUBLE_BIT];
   assign delta_samples[0]        = delta01_reg[DELTA_LO_LSB +: FIELD_W];
   assign delta_samples[1]        = delta01_reg[DELTA_HI_LSB +: FIELD_W];
   assign delta_samples[2]        = delta23_reg[DELTA_LO_LSB +: FIELD_W];
   assign delta_samples[3]        = delta23_reg[DELTA_HI_LSB +: FIELD_W];
   assign delta_samples[4]        = delta45_reg[DELTA_LO_LSB +: FIELD_W];
   assign delta_samples[5]        = delta45_reg[DELTA_HI_LSB +: FIELD_W];

   // only six samples are stored; a larger count is clamped rather than reading junk
   assign used_count = (sample_count > 4'(NUM_SAMPLES)) ? 4'(NUM_SAMPLES)
                                                         : sample_count;

   ////////////////////////////////////////////////////////////////////////////
   // step timing and waveform sequencer

   logic               step_done;
   logic               run_state;
   ss_state_t          state_reg;
   ss_state_t          state_next;
   logic [FIELD_W-1:0] index_reg;
   logic [FIELD_W-1:0] index_next;
   logic [WAVE_W-1:0]  wave_reg;
   logic [WAVE_W-1:0]  wave_next;

   // the timer counts only in the run state and is cleared while idle
   assign run_state = (state_reg == SS_RUN);

   ss_step_timer u_step_timer (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .run       (run_state),
      .period    (step_period_cycles),
      .step_done (step_done)
   );

   always_comb begin
      state_next = state_reg;
      index_next = index_reg;
      wave_next  = wave_reg;
      case (state_reg)
         SS_IDLE: begin
            index_next = '0;
            wave_next  = '0;
            if (step_period_cycles != '0) begin
               state_next = SS_RUN;
               wave_next  = WAVE_W'(start_offset);
            end
         end
         SS_RUN: begin
            // a zero step period stops the waveform at once, even mid-step
            if (step_period_cycles == '0) begin
               state_next = SS_IDLE;
               index_next = '0;
               wave_next  = '0;
            end else if (step_done) begin
               if (index_reg >= used_count) begin
                  index_next = '0;
                  wave_next  = WAVE_W'(start_offset);
               end else begin
                  index_next = index_reg + 4'h1;
                  wave_next  = wave_reg + WAVE_W'(delta_samples[index_reg[2:0]]);
               end
            end
         end
         default: begin
            state_next = SS_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= SS_IDLE;
         index_reg <= '0;
         wave_reg  <= '0;
      end else begin
         state_reg <= state_next;
         index_reg <= index_next;
         wave_reg  <= wave_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output shaping: lsb dither and doubling

   logic [7:0]       lfsr_reg;
   logic [7:0]       lfsr_next;
   logic [OUT_W-1:0] out_reg;
   logic [OUT_W-1:0] out_next;
   logic [OUT_W-1:0] dithered;
   logic             dither_bit;
   logic             strobe_reg;
   logic             strobe_next;

   always_comb begin
      lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);
      // dither toggles only the lsb so the mean offset moves by half a step at most
      // the lfsr free-runs while idle; gating it keeps an idle output at zero
      dither_bit = lsb_dither_enable & lfsr_reg[0] & run_state;
      dithered = OUT_W'(wave_reg) ^ OUT_W'(dither_bit);
      if (modulator_output_double) begin
         out_next = dithered << 1;
      end else begin
         out_next = dithered;
      end
      strobe_next = step_done;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lfsr_reg   <= LFSR_SEED;
         out_reg    <= '0;
         strobe_reg <= 1'b0;
      end else begin
         lfsr_reg   <= lfsr_next;
         out_reg    <= out_next;
         strobe_reg <= strobe_next;
      end
   end

   assign frac_offset = out_reg;
   assign ss_active   = run_state;
   assign step_strobe = strobe_reg;

endmodule

/* File: test/ss_mod_monitor.sv */
// Purpose: port checks of the spread-spectrum modulator
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound into every modulator instance
`timescale 1ns/100ps
module ss_mod_monitor (
   // clock and reset
   input wire logic                          sys_clk,
   input wire logic                          resetn,
   // configuration port
   input wire logic                          cfg_wr,
   input wire logic [ss_mod_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [ss_mod_pkg::DATA_W-1:0] cfg_wdata,
   input wire logic [ss_mod_pkg::DATA_W-1:0] cfg_rdata,
   // feedback divider side
   input wire logic [ss_mod_pkg::OUT_W-1:0]  frac_offset,
   input wire logic                          ss_active,
   input wire logic                          step_strobe
);
   import ss_mod_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic mapped;
   assign mapped = cfg_addr inside {[8'h60:8'h64]};
   sequence s_ctl_wr;
      cfg_wr && cfg_addr == SS_STEP_AND_SAMPLE_COUNT_PLL0;
   endsequence
   a_run_on_write: assert property (s_ctl_wr ##0 cfg_wdata[7:4] != 4'h0 |=> ##1 ss_active)
      else $error("modulator did not start");
   a_off_on_write: assert property (s_ctl_wr ##0 cfg_wdata[7:4] == 4'h0 |=> ##1 !ss_active)
      else $error("modulator did not stop");
   a_active_cause: assert property ($changed(ss_active) |->
      $past(cfg_wr, 2) && $past(cfg_addr, 2) == SS_STEP_AND_SAMPLE_COUNT_PLL0)
      else $error("run state changed without a control write");
   a_idle_out_zero: assert property (!ss_active && $past(!ss_active) |-> frac_offset == 10'h000)
      else $error("offset not zero while idle");
   a_strobe_needs_run: assert property (step_strobe |-> $past(ss_active))
      else $error("step strobe while idle");
   a_frac_move_run: assert property ($changed(frac_offset) |->
      $past(ss_active) || $past(ss_active, 2))
      else $error("offset moved while idle");
   a_write_read_back: assert property (cfg_wr && mapped ##1 !cfg_wr && $stable(cfg_addr)
      |=> cfg_rdata == $past(cfg_wdata, 2))
      else $error("register read back differs");
   a_unmapped_zero: assert property (!mapped |=> cfg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind pll_spread_spectrum_modulator ss_mod_monitor u_mon (.sys_clk(sys_clk), .resetn(resetn),
   .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
   .frac_offset(frac_offset), .ss_active(ss_active), .step_strobe(step_strobe));

/* File: test/fb_div_model.sv */
// Purpose: feedback divider stand-in that takes one offset per step
// Assumes: offset is valid in the cycle of step_strobe
// Notes:   counts steps so idle periods can be checked
`timescale 1ns/100ps
module fb_div_model (
   // clock and reset
   input wire logic                         sys_clk,
   input wire logic                         resetn,
   // from the modulator
   input wire logic [ss_mod_pkg::OUT_W-1:0] frac_offset,
   input wire logic                         step_strobe,
   // observed
   output logic     [ss_mod_pkg::OUT_W-1:0] held_offset,
   output int                               steps
);
   import ss_mod_pkg::*;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         held_offset <= '0;
         steps <= 0;
      end else if (step_strobe) begin
         held_offset <= frac_offset;
         steps <= steps + 1;
      end
   end
endmodule

/* File: test/tb.sv */
// Purpose: random and corner runs of the spread-spectrum modulator
// Assumes: inputs change 1 ns after the rising edge
// Notes:   dithered runs check every bit but the dithered one
`timescale 1ns/100ps
module tb
   import ss_mod_pkg::*;
;
   logic sys_clk = 1'b0, resetn = 1'b0, cfg_wr = 1'b0, ss_active, step_strobe, dbl, dth;
   logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, v;
   logic [9:0]  frac_offset, held, m;
   logic [15:0] rnd = 16'd34980;
   logic [5:0]  ofs;
   logic [3:0]  per, cnt, dl[6];
   int          failures = 0, checks_done = 0, steps, s0, n, i, r, hits;
   always #5 sys_clk = ~sys_clk;
   pll_spread_spectrum_modulator dut (.sys_clk(sys_clk), .resetn(resetn), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .frac_offset(frac_offset), .ss_active(ss_active), .step_strobe(step_strobe));
   fb_div_model model (.sys_clk(sys_clk), .resetn(resetn), .frac_offset(frac_offset),
      .step_strobe(step_strobe), .held_offset(held), .steps(steps));
   ////////////////////////////////////////////////////////////////
   function logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // waveform value i cycles after the first offset shows at the output
   function logic [9:0] exp_wave(input int i);
      logic [7:0] w;
      w = {2'h0, ofs};
      for (int k = 0; k < (i / int'(per)) % (n + 1); k++) w = w + {4'h0, dl[k]};
      return {2'h0, w} << dbl;
   endfunction
   task cmp(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      @(posedge sys_clk);
      #1;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      cfg_wr = 1'b0;
      cfg_addr = a;
      @(posedge sys_clk);
      #1 d = cfg_rdata;
   endtask
   task close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 resetn = 1'b1;
      for (r = 8'h60; r <= 8'h66; r++) begin
         rd(r[7:0], v);
         cmp({2'h0, v}, 10'h000);
      end
      for (r = 8'h61; r <= 8'h64; r++) begin
         rnd = lfsr(rnd);
         wr(r[7:0], rnd[7:0]);
         rd(r[7:0], v);
         cmp({2'h0, v}, {2'h0, rnd[7:0]});
      end
      // corners: count zero, count above six, dithered run
      for (r = 0; r < 6; r++) begin
         rnd = lfsr(rnd);
         per = 4'h1 + rnd[1:0] % 3;
         cnt = (r == 0) ? 4'h0 : (r == 1) ? 4'hf : rnd[5:2];
         n = (cnt > 6) ? 6 : cnt;
         ofs = rnd[15:10];
         dbl = rnd[9];
         dth = (r == 5);
         wr(8'h60, 8'h00);
         wr(8'h61, {dth, dbl, ofs});
         for (i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            dl[i] = rnd[3:0];
         end
         for (i = 0; i < 3; i++) wr(8'h62 + i[7:0], {dl[2 * i + 1], dl[2 * i]});
         wr(8'h60, {per, cnt});
         cfg_wr = 1'b0;
         @(posedge sys_clk);
         m = dth ? ~(10'h001 << dbl) : 10'h3ff;
         hits = 0;
         // a dithered run is stretched so the lfsr surely shows both values
         for (i = 0; i < 3 * int'(per) * (n + 1) + (dth ? 64 : 0); i++) begin
            @(posedge sys_clk);
            #1 cmp(frac_offset & m, exp_wave(i) & m);
            if (i > 0 && i % int'(per) == 0) cmp(held & m, exp_wave(i - 1) & m);
            if (((frac_offset ^ exp_wave(i)) & ~m) != 10'h000) hits++;
         end
         if (dth) cmp(10'(hits > 0), 10'h001);
      end
      wr(8'h60, 8'h00);
      cfg_wr = 1'b0;
      repeat (3) @(posedge sys_clk);
      s0 = steps;
      repeat (20) @(posedge sys_clk);
      #1 cmp(10'(steps - s0), 10'h000);
      cmp(frac_offset, 10'h000);
      close_out();
   end
endmodule
